// >>> logic/cccs_pkg.sv
// constants for the calibration command sequencer
package cccs_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_DATA     = 8'h04;
  localparam logic [7:0] OFF_CODE_CHR = 8'h08;
  localparam logic [7:0] OFF_MSG_CHR  = 8'h0C;
  localparam logic [7:0] OFF_MSG_LEN  = 8'h10;
  localparam logic [7:0] OFF_MSG_IDX  = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_COUNT    = 8'h1C;
  // command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OP_W    = 4;
  localparam int CMD_ARG_LSB = 4;
  localparam int CMD_ARG_W   = 2;
  localparam int CMD_OUT_BIT = 8;
  // command opcodes
  localparam logic [3:0] OP_VPOINT = 4'h1; // voltage_point_select
  localparam logic [3:0] OP_VDATA  = 4'h2;
  localparam logic [3:0] OP_CPOINT = 4'h3; // current_point_select
  localparam logic [3:0] OP_CDATA  = 4'h4;
  localparam logic [3:0] OP_GUARD  = 4'h5; // guard_calibrate_cmd
  localparam logic [3:0] OP_LOCK   = 4'h6; // calib_lock_state_cmd
  localparam logic [3:0] OP_PASS   = 4'h7; // calib_passcode_cmd
  localparam logic [3:0] OP_MSGCLR = 4'h8; // calib_message_cmd start
  // status bit positions
  localparam int ST_SECURED = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_ERR     = 2;
  localparam int ST_VIDX    = 4;
  localparam int ST_CIDX    = 6;
  localparam int ST_OUT     = 8;
  // constant kinds driven to storage
  localparam logic [1:0] KIND_VOLT  = 2'h0;
  localparam logic [1:0] KIND_CURR  = 2'h1;
  localparam logic [1:0] KIND_GUARD = 2'h2;
  // text limits and reset values
  localparam int CODE_MAX = 11;
  localparam int MSG_MAX  = 40;
  localparam logic RST_SECURED = 1'b1;
  // guard calibration duration
  localparam longint CLK_HZ      = 125_000_000;
  localparam longint GUARD_CAL_S = 10;
  localparam longint GUARD_CAL_CYC = GUARD_CAL_S * CLK_HZ;
endpackage

// >>> logic/cccs_text_store.sv
// append-only character store with length and overflow flag
`timescale 1ns/1ps
`default_nettype none
module cccs_text_store #(
  parameter int DEPTH = 11
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // control
  input  wire logic                         clr_i,
  input  wire logic                         push_i,
  input  wire logic [7:0]                   char_i,
  // contents
  output logic      [$clog2(DEPTH+1)-1:0]   len_o,
  output logic                              ovf_o,
  output logic      [DEPTH*8-1:0]           flat_o
);
  localparam int LW = $clog2(DEPTH + 1);
  logic [7:0]    mem_reg [DEPTH];
  logic [LW-1:0] len_reg;
  logic          ovf_reg;
  logic [LW-1:0] wr_pos;
  logic          full;

  if (DEPTH < 1) begin : g_bad
    $error("cccs_text_store: DEPTH must be at least 1");
  end

  // a clear and a push together leave one character
  assign wr_pos = clr_i ? '0 : len_reg;
  assign full   = (wr_pos == LW'(DEPTH));

  // length, overflow and character array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_reg <= '0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= 8'h00;
    end else begin
      if (clr_i) begin
        len_reg <= '0;
        ovf_reg <= 1'b0;
      end
      if (push_i && full) begin
        ovf_reg <= 1'b1; // extra characters are dropped
      end else if (push_i) begin
        mem_reg[wr_pos] <= char_i;
        len_reg         <= wr_pos + 1'b1;
      end
    end
  end

  // flatten the array, first character in the low byte
  always_comb begin
    flat_o = '0;
    for (int i = 0; i < DEPTH; i++) flat_o[i*8 +: 8] = mem_reg[i];
  end

  assign len_o = len_reg;
  assign ovf_o = ovf_reg;
endmodule
`default_nettype wire

// >>> logic/cccs_point_seq.sv
// three-point low/middle/high selection and entry sequencer
`timescale 1ns/1ps
`default_nettype none
module cccs_point_seq #(
  parameter int VAL_W = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // requests
  input  wire logic             clr_i,
  input  wire logic             sel_i,
  input  wire logic [1:0]       level_i,
  input  wire logic             enter_i,
  input  wire logic [VAL_W-1:0] value_i,
  // state
  output logic                  sel_ok_o,
  output logic                  enter_ok_o,
  output logic      [1:0]       idx_o,
  output logic                  done_o,
  output logic      [VAL_W-1:0] low_o,
  output logic      [VAL_W-1:0] high_o
);
  logic [1:0]       idx_reg;
  logic             armed_reg;
  logic             done_reg;
  logic [VAL_W-1:0] val_reg [3];

  if (VAL_W < 2) begin : g_bad
    $error("cccs_point_seq: VAL_W too small");
  end

  // only the next point in order may be selected, then entered
  assign sel_ok_o   = (level_i == idx_reg);
  assign enter_ok_o = armed_reg;

  // point index, armed flag and stored readings
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      idx_reg   <= 2'h0;
      armed_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (sel_i && sel_ok_o) armed_reg <= 1'b1;
      if (enter_i && armed_reg) begin
        val_reg[idx_reg] <= value_i;
        armed_reg        <= 1'b0;
        idx_reg          <= (idx_reg == 2'h2) ? 2'h0 : idx_reg + 2'h1;
        done_reg         <= (idx_reg == 2'h2);
      end
    end
  end

  assign idx_o  = idx_reg;
  assign done_o = done_reg;
  assign low_o  = val_reg[0];
  assign high_o = val_reg[2];
endmodule
`default_nettype wire

// >>> logic/cccs_top.sv
// calibration command sequencer with register port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - count grows by one per accepted point entry
// - count query returns factory-preset running count
// - point commands need unsecured and output on
// - three current readings yield stored current constants
// - three voltage readings yield stored voltage constants
// - point select drives output, pairs next entry
// - new passcode only while unsecured, eleven characters
// - lock command secures or unsecures with passcode
// - lock query reads 0 unsecured, 1 secured
// - message holds up to forty characters, readable
// - guard calibration unsecured, output on, ten seconds
module cccs_top
  import cccs_pkg::*;
#(
  parameter longint      GUARD_CYC     = GUARD_CAL_CYC,
  parameter logic [31:0] FACTORY_COUNT = 32'h0000_0000
) (
  // clock and reset
  input  wire logic                      CLK_I,
  input  wire logic                      SYS_RST_I,
  // register port
  input  wire logic [cccs_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [cccs_pkg::DATA_W-1:0] WR_DATA_I,
  input  wire logic                      WR_I,
  input  wire logic                      RD_I,
  output logic      [cccs_pkg::DATA_W-1:0] RD_DATA_O,
  // output state pins
  input  wire logic [1:0]                OUT_ON_I,
  // calibration point drive
  output logic                           CAL_DRIVE_O,
  output logic                           CAL_QTY_O,
  output logic      [1:0]                CAL_LEVEL_O,
  output logic                           CAL_OUT_O,
  output logic                           GUARD_BUSY_O,
  // constant storage write
  output logic                           CONST_WE_O,
  output logic      [1:0]                CONST_KIND_O,
  output logic                           CONST_OUT_O,
  output logic      [31:0]               CONST_DATA_O
);
  import cccs_pkg::*;
  typedef enum logic {CCCS_IDLE, CCCS_GUARD} cccs_state_t;
  localparam int CLW = $clog2(CODE_MAX + 1);
  localparam int MLW = $clog2(MSG_MAX + 1);

  if (GUARD_CYC < 1 || GUARD_CYC > 64'h7FFF_FFFF) begin : g_bad
    $error("cccs_top: GUARD_CYC out of range");
  end

  // passcodes match when lengths and used characters agree
  function automatic logic code_match(input logic [CODE_MAX*8-1:0] a,
      input logic [CLW-1:0] al, input logic [CODE_MAX*8-1:0] b,
      input logic [CLW-1:0] bl);
    logic eq;
    eq = (al == bl);
    for (int i = 0; i < CODE_MAX; i++) begin
      if (CLW'(i) < al && a[i*8 +: 8] != b[i*8 +: 8]) eq = 1'b0;
    end
    return eq;
  endfunction

  cccs_state_t        state_reg, state_next;
  logic [1:0]         on_meta_reg, on_reg;
  logic               secured_reg, err_reg, cur_out_reg;
  logic [31:0]        count_reg, data_reg, gcnt_reg;
  logic [CODE_MAX*8-1:0] code_reg;
  logic [CLW-1:0]     code_len_reg;
  logic [MLW-1:0]     msg_idx_reg;
  logic [DATA_W-1:0]  rd_next;
  logic [CODE_MAX*8-1:0] ent_flat;
  logic [CLW-1:0]     ent_len;
  logic               ent_ovf;
  logic [MSG_MAX*8-1:0] msg_flat;
  logic [MLW-1:0]     msg_len;
  logic               v_sel_ok, v_ent_ok, c_sel_ok, c_ent_ok;
  logic               v_done, c_done;
  logic [1:0]         v_idx, c_idx;
  logic [15:0]        v_low, v_high, c_low, c_high;

  // bus decode
  wire wr_cmd  = WR_I && ADDR_I == OFF_CMD;
  wire wr_data = WR_I && ADDR_I == OFF_DATA;
  wire wr_code = WR_I && ADDR_I == OFF_CODE_CHR;
  wire wr_msg  = WR_I && ADDR_I == OFF_MSG_CHR;
  wire wr_midx = WR_I && ADDR_I == OFF_MSG_IDX;
  wire wr_stat = WR_I && ADDR_I == OFF_STATUS;
  wire rd_msg  = RD_I && ADDR_I == OFF_MSG_CHR;
  wire [3:0] op  = WR_DATA_I[CMD_OP_LSB +: CMD_OP_W];
  wire [1:0] arg = WR_DATA_I[CMD_ARG_LSB +: CMD_ARG_W];
  wire out_sel   = WR_DATA_I[CMD_OUT_BIT];

  // command preconditions
  wire busy     = (state_reg == CCCS_GUARD);
  wire seq_open = (v_idx != 2'h0) || (c_idx != 2'h0) || v_ent_ok || c_ent_ok;
  wire out_ok   = !seq_open || out_sel == cur_out_reg;
  wire may_cal  = !secured_reg && on_reg[out_sel] && !busy && out_ok;
  wire code_ok  = code_match(ent_flat, ent_len, code_reg, code_len_reg);
  wire cmd_ok   = (op == OP_VPOINT) ? may_cal && v_sel_ok :
                  (op == OP_VDATA)  ? may_cal && v_ent_ok :
                  (op == OP_CPOINT) ? may_cal && c_sel_ok :
                  (op == OP_CDATA)  ? may_cal && c_ent_ok :
                  (op == OP_GUARD)  ? may_cal && !seq_open :
                  (op == OP_LOCK)   ? !busy && code_ok && !ent_ovf :
                  (op == OP_PASS)   ? !busy && !secured_reg && !ent_ovf :
                  (op == OP_MSGCLR);
  wire acc      = wr_cmd && cmd_ok;
  wire cmd_bad  = wr_cmd && !cmd_ok;
  wire acc_v_sel = acc && op == OP_VPOINT;
  wire acc_c_sel = acc && op == OP_CPOINT;
  wire acc_enter = acc && (op == OP_VDATA || op == OP_CDATA);
  wire acc_point = acc_v_sel || acc_c_sel || acc_enter;
  wire guard_go  = acc && op == OP_GUARD;
  wire guard_end = busy && gcnt_reg == 32'(GUARD_CYC - 1);
  // sequences restart when locked or their output switches off
  wire seq_clr   = secured_reg || (!on_reg[cur_out_reg] && !acc_point);
  // entered code is consumed by accepted lock and passcode commands
  wire ent_clr   = acc && (op == OP_LOCK || op == OP_PASS);

  cccs_point_seq #(.VAL_W(16)) u_vseq (
    .clk_i      (CLK_I),
    .rst_i      (SYS_RST_I),
    .clr_i      (seq_clr),
    .sel_i      (acc_v_sel),
    .level_i    (arg),
    .enter_i    (acc && op == OP_VDATA),
    .value_i    (data_reg[15:0]),
    .sel_ok_o   (v_sel_ok),
    .enter_ok_o (v_ent_ok),
    .idx_o      (v_idx),
    .done_o     (v_done),
    .low_o      (v_low),
    .high_o     (v_high)
  );

  cccs_point_seq #(.VAL_W(16)) u_cseq (
    .clk_i      (CLK_I),
    .rst_i      (SYS_RST_I),
    .clr_i      (seq_clr),
    .sel_i      (acc_c_sel),
    .level_i    (arg),
    .enter_i    (acc && op == OP_CDATA),
    .value_i    (data_reg[15:0]),
    .sel_ok_o   (c_sel_ok),
    .enter_ok_o (c_ent_ok),
    .idx_o      (c_idx),
    .done_o     (c_done),
    .low_o      (c_low),
    .high_o     (c_high)
  );

  cccs_text_store #(.DEPTH(CODE_MAX)) u_code_in (
    .clk_i  (CLK_I),
    .rst_i  (SYS_RST_I),
    .clr_i  (ent_clr),
    .push_i (wr_code),
    .char_i (WR_DATA_I[7:0]),
    .len_o  (ent_len),
    .ovf_o  (ent_ovf),
    .flat_o (ent_flat)
  );

  cccs_text_store #(.DEPTH(MSG_MAX)) u_msg (
    .clk_i  (CLK_I),
    .rst_i  (SYS_RST_I),
    .clr_i  (acc && op == OP_MSGCLR),
    .push_i (wr_msg),
    .char_i (WR_DATA_I[7:0]),
    .len_o  (msg_len),
    .ovf_o  (),
    .flat_o (msg_flat)
  );

  // read data selection
  always_comb begin
    rd_next = '0;
    case (ADDR_I)
      OFF_DATA:    rd_next = data_reg;
      OFF_MSG_CHR: rd_next = (msg_idx_reg < msg_len) ?
                             32'(msg_flat[msg_idx_reg*8 +: 8]) : 32'h0;
      OFF_MSG_LEN: rd_next = 32'(msg_len);
      OFF_MSG_IDX: rd_next = 32'(msg_idx_reg);
      OFF_STATUS:  rd_next = {23'h0, cur_out_reg, c_idx, v_idx, 1'b0,
                              err_reg, busy, secured_reg};
      OFF_COUNT:   rd_next = count_reg;
      default:     rd_next = '0;
    endcase
  end

  // guard calibration state machine
  always_comb begin
    case (state_reg)
      CCCS_IDLE:  state_next = guard_go ? CCCS_GUARD : CCCS_IDLE;
      CCCS_GUARD: state_next = guard_end ? CCCS_IDLE : CCCS_GUARD;
      default:    state_next = CCCS_IDLE;
    endcase
  end

  // pin synchroniser for the output-on levels
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      on_meta_reg <= 2'h0;
      on_reg      <= 2'h0;
    end else begin
      on_meta_reg <= OUT_ON_I;
      on_reg      <= on_meta_reg;
    end
  end

  // lock state, error flag and stored passcode
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      secured_reg  <= RST_SECURED;
      err_reg      <= 1'b0;
      code_reg     <= '0;
      code_len_reg <= '0;
    end else begin
      if (acc && op == OP_LOCK) secured_reg <= arg[0];
      if (acc && op == OP_PASS) begin
        code_reg     <= ent_flat;
        code_len_reg <= ent_len;
      end
      if (cmd_bad) err_reg <= 1'b1;
      else if (wr_stat && WR_DATA_I[ST_ERR]) err_reg <= 1'b0;
    end
  end

  // count, data word, message pointer and guard timer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg   <= CCCS_IDLE;
      count_reg   <= FACTORY_COUNT;
      data_reg    <= 32'h0;
      msg_idx_reg <= '0;
      gcnt_reg    <= 32'h0;
      cur_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (acc_enter) count_reg <= count_reg + 32'h1;
      if (wr_data) data_reg <= WR_DATA_I;
      if (wr_midx) msg_idx_reg <= WR_DATA_I[MLW-1:0];
      else if (rd_msg && msg_idx_reg < msg_len) msg_idx_reg <= msg_idx_reg + 1'b1;
      gcnt_reg <= busy ? gcnt_reg + 32'h1 : 32'h0;
      if (acc_point || guard_go) cur_out_reg <= out_sel;
    end
  end

  // point drive and constant write outputs
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RD_DATA_O    <= '0;
      CAL_DRIVE_O  <= 1'b0;
      CAL_QTY_O    <= 1'b0;
      CAL_LEVEL_O  <= 2'h0;
      CAL_OUT_O    <= 1'b0;
      GUARD_BUSY_O <= 1'b0;
      CONST_WE_O   <= 1'b0;
      CONST_KIND_O <= KIND_VOLT;
      CONST_OUT_O  <= 1'b0;
      CONST_DATA_O <= 32'h0;
    end else begin
      RD_DATA_O    <= RD_I ? rd_next : '0;
      GUARD_BUSY_O <= (state_next == CCCS_GUARD);
      CONST_WE_O   <= v_done || c_done || guard_end;
      CONST_OUT_O  <= cur_out_reg;
      if (seq_clr) CAL_DRIVE_O <= 1'b0;
      else if (acc_v_sel || acc_c_sel) begin
        CAL_DRIVE_O <= 1'b1;
        CAL_QTY_O   <= acc_c_sel;
        CAL_LEVEL_O <= arg;
        CAL_OUT_O   <= out_sel;
      end
      if (v_done) begin
        CONST_KIND_O <= KIND_VOLT;
        CONST_DATA_O <= {v_high - v_low, v_low};
      end else if (c_done) begin
        CONST_KIND_O <= KIND_CURR;
        CONST_DATA_O <= {c_high - c_low, c_low};
      end else if (guard_end) begin
        CONST_KIND_O <= KIND_GUARD;
        CONST_DATA_O <= {16'h0, v_high};
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_COUNT_STEP: assert property (acc_enter |=>
    count_reg == $past(count_reg) + 32'h1) else $error("count not stepped");
  AST_COUNT_HOLD: assert property (!acc_enter |=>
    $stable(count_reg)) else $error("count changed without point");
  AST_SECURE_BLOCK: assert property (secured_reg |->
    !acc_point && !guard_go) else $error("point taken while secured");
  AST_CURR_STORE: assert property (acc && op == OP_CDATA &&
    c_idx == 2'h2 |-> ##2 CONST_WE_O && CONST_KIND_O == KIND_CURR)
    else $error("current constants not stored");
  AST_VOLT_STORE: assert property (acc && op == OP_VDATA &&
    v_idx == 2'h2 |-> ##2 CONST_WE_O && CONST_KIND_O == KIND_VOLT)
    else $error("voltage constants not stored");
  AST_POINT_DRIVE: assert property (acc_v_sel |=>
    CAL_DRIVE_O && !CAL_QTY_O && CAL_LEVEL_O == $past(arg))
    else $error("point not driven");
  AST_PASS_GUARD: assert property (wr_cmd && op == OP_PASS &&
    secured_reg |=> $stable(code_reg)) else $error("passcode changed");
  AST_LOCK_SET: assert property (acc && op == OP_LOCK |=>
    secured_reg == $past(arg[0])) else $error("lock state wrong");
  AST_LOCK_READ: assert property (RD_I && ADDR_I == OFF_STATUS |=>
    RD_DATA_O[ST_SECURED] == $past(secured_reg)) else $error("lock read");
  AST_MSG_LEN: assert property (msg_len <= MLW'(MSG_MAX))
    else $error("message too long");
  AST_GUARD_DONE: assert property (guard_end |=>
    CONST_WE_O && CONST_KIND_O == KIND_GUARD && !GUARD_BUSY_O)
    else $error("guard constant not stored");
  AST_REJECT: assert property (cmd_bad |=> err_reg &&
    $stable(count_reg)) else $error("bad command not flagged");

  COV_VOLT: cover property (v_done);
  COV_CURR: cover property (c_done);
  COV_GUARD: cover property (guard_end);
  COV_UNLOCK: cover property (acc && op == OP_LOCK && !arg[0]);
endmodule
`default_nettype wire

// >>> test/cccs_supply_model.sv
// supply side model: output-on pins and non-volatile constant store
`timescale 1ns/1ps
`default_nettype none
module cccs_supply_model (
  // clock
  input  wire logic        clk_i,
  // output on requests
  input  wire logic [1:0]  en_i,
  output logic      [1:0]  out_on_o,
  // constant storage write
  input  wire logic        we_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic        out_i,
  input  wire logic [31:0] data_i,
  // captured stores
  output logic      [7:0]  n_store_o,
  output logic      [2:0]  last_tag_o,
  output logic      [31:0] last_data_o
);
  // output relay follows the request one cycle late
  initial out_on_o = 2'h0;
  always @(posedge clk_i) out_on_o <= en_i;
  // store capture, one entry per write pulse
  initial n_store_o = 8'h00;
  always @(posedge clk_i) begin
    if (we_i) begin
      n_store_o   <= n_store_o + 8'h01;
      last_tag_o  <= {kind_i, out_i};
      last_data_o <= data_i;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_calibration_command_sequencer.sv
// self-checking bench for the calibration command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_calibration_command_sequencer;
  import cccs_pkg::*;
  typedef struct packed {
    logic [31:0] cmd;
    logic [15:0] val;
    logic [1:0]  lvl;
    logic [7:0]  cnt;
    logic        err;
  } cccs_row_t;
  localparam int GC = 20;
  // voltage rows 0..7, current rows 8..13
  localparam cccs_row_t ROWS [14] = '{
    '{32'h11, 16'h0000, 2'h0, 8'h05, 1'b1},
    '{32'h01, 16'h0000, 2'h0, 8'h05, 1'b0},
    '{32'h02, 16'h0010, 2'h0, 8'h06, 1'b0},
    '{32'h02, 16'h0010, 2'h0, 8'h06, 1'b1},
    '{32'h11, 16'h0000, 2'h1, 8'h06, 1'b0},
    '{32'h02, 16'h0800, 2'h1, 8'h07, 1'b0},
    '{32'h21, 16'h0000, 2'h2, 8'h07, 1'b0},
    '{32'h02, 16'h1000, 2'h2, 8'h08, 1'b0},
    '{32'h03, 16'h0000, 2'h0, 8'h08, 1'b0},
    '{32'h04, 16'h0020, 2'h0, 8'h09, 1'b0},
    '{32'h13, 16'h0000, 2'h1, 8'h09, 1'b0},
    '{32'h04, 16'h0400, 2'h1, 8'h0A, 1'b0},
    '{32'h23, 16'h0000, 2'h2, 8'h0A, 1'b0},
    '{32'h04, 16'h0C00, 2'h2, 8'h0B, 1'b0}};
  logic        CLK_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic [7:0]  ADDR_I = 8'h00;
  logic [31:0] WR_DATA_I = 32'h0;
  logic        WR_I = 1'b0;
  logic        RD_I = 1'b0;
  logic [31:0] RD_DATA_O;
  logic [1:0]  OUT_ON_I;
  logic [1:0]  en = 2'h0;
  logic        CAL_DRIVE_O, CAL_QTY_O, CAL_OUT_O, GUARD_BUSY_O;
  logic [1:0]  CAL_LEVEL_O, CONST_KIND_O;
  logic        CONST_WE_O, CONST_OUT_O;
  logic [31:0] CONST_DATA_O, rdata, last_data;
  logic [7:0]  n_store;
  logic [2:0]  last_tag;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          n;
  // 125 MHz clock
  always #4 CLK_I = ~CLK_I;
  cccs_top #(.GUARD_CYC(GC), .FACTORY_COUNT(32'h0000_0005)) u_cccs_top (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
    .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RD_DATA_O(RD_DATA_O), .OUT_ON_I(OUT_ON_I),
    .CAL_DRIVE_O(CAL_DRIVE_O), .CAL_QTY_O(CAL_QTY_O),
    .CAL_LEVEL_O(CAL_LEVEL_O), .CAL_OUT_O(CAL_OUT_O),
    .GUARD_BUSY_O(GUARD_BUSY_O), .CONST_WE_O(CONST_WE_O),
    .CONST_KIND_O(CONST_KIND_O), .CONST_OUT_O(CONST_OUT_O),
    .CONST_DATA_O(CONST_DATA_O));
  cccs_supply_model u_cccs_supply_model (
    .clk_i(CLK_I), .en_i(en), .out_on_o(OUT_ON_I), .we_i(CONST_WE_O),
    .kind_i(CONST_KIND_O), .out_i(CONST_OUT_O), .data_i(CONST_DATA_O),
    .n_store_o(n_store), .last_tag_o(last_tag), .last_data_o(last_data));
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // one-cycle register bus strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WR_DATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 rdata = RD_DATA_O;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    rd(a);
    chk(nm, e, rdata);
  endtask
  // table rows: command, then count, error flag and point drive
  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      wr(OFF_DATA, {16'h0000, ROWS[i].val});
      wr(OFF_CMD, ROWS[i].cmd);
      repeat (3) @(posedge CLK_I);
      rdc(OFF_COUNT, {24'h0, ROWS[i].cnt}, "count");
      rd(OFF_STATUS);
      chk("err", {31'h0, ROWS[i].err}, {31'h0, rdata[ST_ERR]});
      if (ROWS[i].err)
        wr(OFF_STATUS, 32'h0000_0004);
      else if (ROWS[i].cmd[0])
        chk("drive", {27'h0, 1'b1, ROWS[i].cmd[8], ROWS[i].cmd[1],
            ROWS[i].lvl}, {27'h0, CAL_DRIVE_O, CAL_OUT_O, CAL_QTY_O,
            CAL_LEVEL_O});
    end
  endtask
  initial begin
    repeat (20) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    rdc(OFF_STATUS, 32'h1, "status");
    rdc(OFF_COUNT, 32'h5, "count");
    rdc(8'h20, 32'h0, "unmapped");
    rdc(OFF_MSG_LEN, 32'h0, "msg_len");
    // output 0 on; select and passcode are refused while secured
    en <= 2'h1;
    wr(OFF_CMD, 32'h01);
    wr(OFF_CMD, 32'h07);
    rdc(OFF_STATUS, 32'h5, "status");
    wr(OFF_STATUS, 32'h4);
    wr(OFF_CMD, 32'h06);
    rdc(OFF_STATUS, 32'h0, "status");
    wr(OFF_CODE_CHR, 32'h41);
    wr(OFF_CODE_CHR, 32'h42);
    wr(OFF_CMD, 32'h07);
    wr(OFF_CODE_CHR, 32'h41);
    wr(OFF_CODE_CHR, 32'h42);
    wr(OFF_CMD, 32'h16);
    rdc(OFF_STATUS, 32'h1, "status");
    wr(OFF_CODE_CHR, 32'h41);
    wr(OFF_CMD, 32'h06);
    rdc(OFF_STATUS, 32'h5, "status");
    wr(OFF_STATUS, 32'h4);
    wr(OFF_CODE_CHR, 32'h42);
    wr(OFF_CMD, 32'h06);
    rdc(OFF_STATUS, 32'h0, "status");
    run_rows(0, 7);
    chk("vstore", 32'h8, {21'h0, n_store, last_tag});
    chk("vdata", 32'h0FF0_0010, last_data);
    // guard calibration follows the voltage sequence
    wr(OFF_CMD, 32'h05);
    #1 chk("busy", 32'h1, {31'h0, GUARD_BUSY_O});
    n = 0;
    while (n_store == 8'h01 && n < 100) begin
      @(posedge CLK_I);
      #1 n++;
    end
    if (n >= 100) begin
      $display("mismatch gtime expected store seen timeout");
      error_cnt++;
      finish_test();
    end
    chk("gtime", 32'h1, {31'h0, n == GC + 1 || n == GC + 2});
    chk("gstore", 32'h14, {21'h0, n_store, last_tag});
    chk("gdata", 32'h0000_1000, last_data);
    run_rows(8, 13);
    chk("cstore", 32'h1A, {21'h0, n_store, last_tag});
    chk("cdata", 32'h0BE0_0020, last_data);
    en <= 2'h0;
    repeat (5) @(posedge CLK_I);
    chk("drive_off", 32'h0, {31'h0, CAL_DRIVE_O});
    wr(OFF_CMD, 32'h05);
    rdc(OFF_STATUS, 32'h4, "status");
    // second output alone: its first select must arm and drive at once
    wr(OFF_STATUS, 32'h4);
    en <= 2'h2;
    repeat (4) @(posedge CLK_I);
    wr(OFF_CMD, 32'h101);
    rdc(OFF_STATUS, 32'h100, "status");
    chk("drive1", 32'h18, {27'h0, CAL_DRIVE_O, CAL_OUT_O, CAL_QTY_O,
        CAL_LEVEL_O});
    wr(OFF_CMD, 32'h102);
    wr(OFF_CMD, 32'h111);
    wr(OFF_CMD, 32'h112);
    wr(OFF_CMD, 32'h121);
    wr(OFF_CMD, 32'h122);
    repeat (3) @(posedge CLK_I);
    rdc(OFF_COUNT, 32'hE, "count");
    chk("v1store", 32'h21, {21'h0, n_store, last_tag});
    chk("v1data", 32'h0000_0C00, last_data);
    // message written while unsecured
    wr(OFF_MSG_CHR, 32'h48);
    wr(OFF_MSG_CHR, 32'h49);
    rdc(OFF_MSG_LEN, 32'h2, "msg_len");
    for (int k = 0; k < 40; k++)
      wr(OFF_MSG_CHR, 32'h5A);
    rdc(OFF_MSG_LEN, 32'h28, "msg_len");
    wr(OFF_MSG_IDX, 32'h0);
    rdc(OFF_MSG_CHR, 32'h48, "msg_chr");
    rdc(OFF_MSG_CHR, 32'h49, "msg_chr");
    wr(OFF_MSG_IDX, 32'h27);
    rdc(OFF_MSG_CHR, 32'h5A, "msg_chr");
    rdc(OFF_MSG_CHR, 32'h0, "msg_chr");
    // second reset in mid-run
    SYS_RST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    rdc(OFF_STATUS, 32'h1, "status");
    rdc(OFF_COUNT, 32'h5, "count");
    finish_test();
  end
endmodule
`default_nettype wire
